// File: rtl/vrc_top.sv
//////////////////////////////////////////////////////////////////////////////////////////
//
// Decided for this implementation: strobed register access and the register addresses.
module vrc_top (
  // clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        rstn_i,
  // peripheral request pins
  input  wire logic [vrc_pkg::NUM_REQ-1:0] req_i,
  // register port
  input  wire logic [vrc_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [vrc_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [vrc_pkg::DATA_W-1:0]  rdata_o,
  // processor interrupt inputs
  output logic                             fast_interrupt_line_o,
  output logic                             std_interrupt_line_o,
  // controller event interrupt
  output logic                             int_o
);
  import vrc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [NUM_REQ-1:0]                       pol;
    logic [NUM_REQ-1:0]                       sw;
    logic [NUM_REQ-1:0]                       tgt;
    vrc_prio_t [NUM_REQ-1:0]                  prio;
    vrc_prio_t [NUM_TGT-1:0]                  thr;
    vrc_prio_t [NUM_TGT-1:0][STK_DEPTH-1:0]   stk;
    logic [NUM_TGT-1:0][SP_W-1:0]             sp;
    logic [NUM_TGT-1:0]                       hit_d;
    logic [EV_W-1:0]                          stat;
    logic [EV_W-1:0]                          mask;
    logic [DATA_W-1:0]                        rdata;
  } vrc_top_s;

  vrc_top_s st;
  vrc_top_s next_st;

  logic [NUM_REQ-1:0]      sync_req;
  logic [NUM_REQ-1:0]      raw;
  logic [NUM_TGT-1:0]      hit;
  vrc_idx_t  [NUM_TGT-1:0] vidx;
  vrc_prio_t [NUM_TGT-1:0] vprio;
  logic [NUM_TGT-1:0][NUM_REQ-1:0] pend;

  //////////////////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic is_cfg(input logic [ADDR_W-1:0] a);
    is_cfg = (a >= A_CFG_BASE) && (a < A_CFG_END) && (a[1:0] == 2'b00);
  endfunction

  function automatic vrc_idx_t cfg_sel(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off     = a - A_CFG_BASE;
    cfg_sel = off[IDX_W+1:2];
  endfunction

  function automatic logic [DATA_W-1:0] lo(input logic [NUM_REQ-1:0] v);
    lo = v[LO_W-1:0];
  endfunction

  function automatic logic [DATA_W-1:0] hi(input logic [NUM_REQ-1:0] v);
    hi = DATA_W'(v[NUM_REQ-1:LO_W]);
  endfunction

  function automatic logic [DATA_W-1:0] vec(input logic h, input vrc_idx_t i, input vrc_prio_t p);
    vec                              = '0;
    vec[VEC_HIT_POS]                 = h;
    vec[VEC_PRIO_POS +: PRIO_W]      = p;
    vec[IDX_W-1:0]                   = i;
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////
  // request path

  vrc_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .d_i       (req_i),
    .q_o       (sync_req)
  );

  // polarity bit set inverts the pin, software request ORs in
  assign raw = (sync_req ^ st.pol) | st.sw;

  vrc_tgt_if tgt_if[NUM_TGT] ();

  genvar g;
  generate
    for (g = 0; g < NUM_TGT; g++) begin : g_tgt
      vrc_arb u_arb (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .act_i     (raw),
        .prio_i    (st.prio),
        .tgt_i     (st.tgt),
        .tgt_sel_i ((g == T_STD) ? TGT_STD : TGT_FAST),
        .thr_i     (st.thr[g]),
        .res       (tgt_if[g])
      );
      assign hit[g]   = tgt_if[g].hit;
      assign vidx[g]  = tgt_if[g].idx;
      assign vprio[g] = tgt_if[g].prio;

      // qualified requests per target, for software inspection
      for (genvar i = 0; i < NUM_REQ; i++) begin : g_pend
        assign pend[g][i] = raw[i] && (st.tgt[i] == ((g == T_STD) ? TGT_STD : TGT_FAST)) &&
                            (st.prio[i] != '0) && (st.prio[i] > st.thr[g]);
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////////////////
  // register file, nesting stack and events

  always_comb begin
    logic [EV_W-1:0] ev;
    vrc_idx_t        ci;
    logic [SP_W-1:0] nsp;
    ev      = '0;
    ci      = cfg_sel(addr_i);
    nsp     = '0;
    next_st = st;

    // write port
    if (wr_i) begin
      case (addr_i)
        A_POL_LO:   next_st.pol[LO_W-1:0] = wdata_i;
        A_POL_HI:   next_st.pol[NUM_REQ-1:LO_W] = wdata_i[HI_W-1:0];
        A_SW_LO:    next_st.sw[LO_W-1:0] = wdata_i;
        A_SW_HI:    next_st.sw[NUM_REQ-1:LO_W] = wdata_i[HI_W-1:0];
        A_SWSET_LO: next_st.sw[LO_W-1:0] = st.sw[LO_W-1:0] | wdata_i;
        A_SWSET_HI: next_st.sw[NUM_REQ-1:LO_W] = st.sw[NUM_REQ-1:LO_W] | wdata_i[HI_W-1:0];
        A_SWCLR_LO: next_st.sw[LO_W-1:0] = st.sw[LO_W-1:0] & ~wdata_i;
        A_SWCLR_HI: next_st.sw[NUM_REQ-1:LO_W] = st.sw[NUM_REQ-1:LO_W] & ~wdata_i[HI_W-1:0];
        A_THR_F:    next_st.thr[T_FAST] = wdata_i[PRIO_W-1:0];
        A_THR_S:    next_st.thr[T_STD] = wdata_i[PRIO_W-1:0];
        A_MASK:     next_st.mask = wdata_i[EV_W-1:0];
        A_NEST_IN: begin
          // push threshold, raise it to the serviced level so only stronger requests preempt
          for (int t = 0; t < NUM_TGT; t++) begin
            if (wdata_i[t]) begin
              if (st.sp[t] < SP_W'(STK_DEPTH)) begin
                next_st.stk[t][st.sp[t][SP_W-2:0]] = st.thr[t];
                next_st.sp[t]                      = st.sp[t] + SP_W'(1);
                if (vprio[t] > st.thr[t]) begin
                  next_st.thr[t] = vprio[t];
                end
              end else begin
                ev[EV_NEST] = 1'b1;
              end
            end
          end
        end
        A_NEST_OUT: begin
          for (int t = 0; t < NUM_TGT; t++) begin
            if (wdata_i[t]) begin
              if (st.sp[t] != '0) begin
                nsp            = st.sp[t] - SP_W'(1);
                next_st.sp[t]  = nsp;
                next_st.thr[t] = st.stk[t][nsp[SP_W-2:0]];
              end else begin
                ev[EV_NEST] = 1'b1;
              end
            end
          end
        end
        default: begin
          if (is_cfg(addr_i)) begin
            next_st.prio[ci] = wdata_i[PRIO_W-1:0];
            next_st.tgt[ci]  = wdata_i[CFG_TGT_POS];
          end
        end
      endcase
    end

    // read port, answer in the following cycle, unmapped reads zero
    next_st.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        A_POL_LO:   next_st.rdata = lo(st.pol);
        A_POL_HI:   next_st.rdata = hi(st.pol);
        A_SW_LO:    next_st.rdata = lo(st.sw);
        A_SW_HI:    next_st.rdata = hi(st.sw);
        A_RAW_LO:   next_st.rdata = lo(raw);
        A_RAW_HI:   next_st.rdata = hi(raw);
        A_PNDF_LO:  next_st.rdata = lo(pend[T_FAST]);
        A_PNDF_HI:  next_st.rdata = hi(pend[T_FAST]);
        A_PNDS_LO:  next_st.rdata = lo(pend[T_STD]);
        A_PNDS_HI:  next_st.rdata = hi(pend[T_STD]);
        A_THR_F:    next_st.rdata = DATA_W'(st.thr[T_FAST]);
        A_THR_S:    next_st.rdata = DATA_W'(st.thr[T_STD]);
        A_VEC_F:    next_st.rdata = vec(hit[T_FAST], vidx[T_FAST], vprio[T_FAST]);
        A_VEC_S:    next_st.rdata = vec(hit[T_STD], vidx[T_STD], vprio[T_STD]);
        A_NEST_LVL: next_st.rdata = DATA_W'({st.sp[T_STD], st.sp[T_FAST]});
        A_STAT:     next_st.rdata = DATA_W'(st.stat);
        A_MASK:     next_st.rdata = DATA_W'(st.mask);
        default: begin
          if (is_cfg(addr_i)) begin
            next_st.rdata                = DATA_W'(st.prio[ci]);
            next_st.rdata[CFG_TGT_POS]   = st.tgt[ci];
          end
        end
      endcase
    end

    // sticky events: new assertion of each target line; set beats read clear
    next_st.hit_d   = hit;
    ev[EV_FAST]     = hit[T_FAST] & ~st.hit_d[T_FAST];
    ev[EV_STD]      = hit[T_STD] & ~st.hit_d[T_STD];
    if (rd_i && (addr_i == A_STAT)) begin
      next_st.stat = '0;
    end
    next_st.stat = next_st.stat | ev;
  end

  // configuration returns to defaults on each warm reset
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign fast_interrupt_line_o = hit[T_FAST];
  assign std_interrupt_line_o  = hit[T_STD];
  assign rdata_o               = st.rdata;
  assign int_o                 = |(st.stat & st.mask);
endmodule

// File: rtl/vrc_pkg.sv
package vrc_pkg;
  localparam int NUM_REQ   = 56;
  localparam int NUM_TGT   = 2;
  localparam int PRIO_W    = 4;
  localparam int IDX_W     = 6;
  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 32;
  localparam int LO_W      = 32;
  localparam int HI_W      = NUM_REQ - LO_W;
  localparam int STK_DEPTH = 8;
  localparam int SP_W      = 4;
  localparam int EV_W      = 3;

  // target encoding held per request input
  localparam logic TGT_FAST = 1'b0;
  localparam logic TGT_STD  = 1'b1;
  localparam int   T_FAST   = 0;
  localparam int   T_STD    = 1;

  // register byte addresses
  localparam logic [ADDR_W-1:0] A_POL_LO   = 10'h000;
  localparam logic [ADDR_W-1:0] A_POL_HI   = 10'h004;
  localparam logic [ADDR_W-1:0] A_SW_LO    = 10'h008;
  localparam logic [ADDR_W-1:0] A_SW_HI    = 10'h00c;
  localparam logic [ADDR_W-1:0] A_SWSET_LO = 10'h010;
  localparam logic [ADDR_W-1:0] A_SWSET_HI = 10'h014;
  localparam logic [ADDR_W-1:0] A_SWCLR_LO = 10'h018;
  localparam logic [ADDR_W-1:0] A_SWCLR_HI = 10'h01c;
  localparam logic [ADDR_W-1:0] A_RAW_LO   = 10'h020;
  localparam logic [ADDR_W-1:0] A_RAW_HI   = 10'h024;
  localparam logic [ADDR_W-1:0] A_PNDF_LO  = 10'h028;
  localparam logic [ADDR_W-1:0] A_PNDF_HI  = 10'h02c;
  localparam logic [ADDR_W-1:0] A_PNDS_LO  = 10'h030;
  localparam logic [ADDR_W-1:0] A_PNDS_HI  = 10'h034;
  localparam logic [ADDR_W-1:0] A_THR_F    = 10'h038;
  localparam logic [ADDR_W-1:0] A_THR_S    = 10'h03c;
  localparam logic [ADDR_W-1:0] A_VEC_F    = 10'h040;
  localparam logic [ADDR_W-1:0] A_VEC_S    = 10'h044;
  localparam logic [ADDR_W-1:0] A_NEST_IN  = 10'h048;
  localparam logic [ADDR_W-1:0] A_NEST_OUT = 10'h04c;
  localparam logic [ADDR_W-1:0] A_NEST_LVL = 10'h050;
  localparam logic [ADDR_W-1:0] A_STAT     = 10'h054;
  localparam logic [ADDR_W-1:0] A_MASK     = 10'h058;
  localparam logic [ADDR_W-1:0] A_CFG_BASE = 10'h100;
  localparam logic [ADDR_W-1:0] A_CFG_END  = 10'h1e0;

  // field positions
  localparam int CFG_TGT_POS  = 8;
  localparam int VEC_PRIO_POS = 8;
  localparam int VEC_HIT_POS  = 31;
  localparam int LVL_STD_POS  = 4;
  localparam int EV_FAST      = 0;
  localparam int EV_STD       = 1;
  localparam int EV_NEST      = 2;

  typedef logic [PRIO_W-1:0] vrc_prio_t;
  typedef logic [IDX_W-1:0]  vrc_idx_t;
endpackage

// File: rtl/vrc_tgt_if.sv
interface vrc_tgt_if;
  logic               hit;
  vrc_pkg::vrc_idx_t  idx;
  vrc_pkg::vrc_prio_t prio;

  modport src (output hit, output idx, output prio);
  modport dst (input hit, input idx, input prio);
endinterface

// File: rtl/vrc_sync.sv
module vrc_sync (
  // clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        rstn_i,
  // asynchronous request pins and synchronised copy
  input  wire logic [vrc_pkg::NUM_REQ-1:0] d_i,
  output logic      [vrc_pkg::NUM_REQ-1:0] q_o
);
  import vrc_pkg::*;

  typedef struct packed {
    logic [NUM_REQ-1:0] s1;
    logic [NUM_REQ-1:0] s2;
  } vrc_sync_s;

  vrc_sync_s st;
  vrc_sync_s next_st;

  always_comb begin
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.s2;
endmodule

// File: rtl/vrc_arb.sv
module vrc_arb (
  // clock and reset
  input  wire logic                                   sys_clk_i,
  input  wire logic                                   rstn_i,
  // request state and configuration
  input  wire logic               [vrc_pkg::NUM_REQ-1:0] act_i,
  input  wire vrc_pkg::vrc_prio_t [vrc_pkg::NUM_REQ-1:0] prio_i,
  input  wire logic               [vrc_pkg::NUM_REQ-1:0] tgt_i,
  input  wire logic                                   tgt_sel_i,
  input  wire vrc_pkg::vrc_prio_t                     thr_i,
  // winner of this target
  vrc_tgt_if.src                                      res
);
  import vrc_pkg::*;

  typedef struct packed {
    logic      hit;
    vrc_idx_t  idx;
    vrc_prio_t prio;
  } vrc_arb_s;

  vrc_arb_s st;
  vrc_arb_s next_st;

  // strict greater-than keeps the lowest index on equal priority
  always_comb begin
    next_st = '0;
    for (int i = 0; i < NUM_REQ; i++) begin
      if (act_i[i] && (tgt_i[i] == tgt_sel_i) && (prio_i[i] != '0) && (prio_i[i] > thr_i) &&
          (!next_st.hit || (prio_i[i] > next_st.prio))) begin
        next_st.hit  = 1'b1;
        next_st.idx  = IDX_W'(i);
        next_st.prio = prio_i[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign res.hit  = st.hit;
  assign res.idx  = st.idx;
  assign res.prio = st.prio;
endmodule

// File: bench/vrc_cpu_model.sv
module vrc_cpu_model (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  // interrupt inputs of the core
  input  wire logic       fast_i,
  input  wire logic       std_i,
  // service entries taken
  output logic      [7:0] fast_cnt_o,
  output logic      [7:0] std_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fast_q;
  logic std_q;

  // the core enters a service routine on each rising level
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      fast_q     <= 1'b0;
      std_q      <= 1'b0;
      fast_cnt_o <= 8'h00;
      std_cnt_o  <= 8'h00;
    end else begin
      fast_q <= fast_i;
      std_q  <= std_i;
      if (fast_i && !fast_q) fast_cnt_o <= fast_cnt_o + 8'h01;
      if (std_i && !std_q) std_cnt_o <= std_cnt_o + 8'h01;
    end
  end
endmodule

// File: bench/vrc_properties.sv
module vrc_chk (
  // clock and reset
  input wire logic                        sys_clk_i,
  input wire logic                        rstn_i,
  // pins and register port
  input wire logic [vrc_pkg::NUM_REQ-1:0] req_i,
  input wire logic [vrc_pkg::ADDR_W-1:0]  addr_i,
  input wire logic [vrc_pkg::DATA_W-1:0]  wdata_i,
  input wire logic                        wr_i,
  input wire logic                        rd_i,
  input wire logic [vrc_pkg::DATA_W-1:0]  rdata_o,
  // outputs
  input wire logic                        fast_interrupt_line_o,
  input wire logic                        std_interrupt_line_o,
  input wire logic                        int_o
);
  import vrc_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  logic       raw_clean;
  logic       prio_clean;
  logic [2:0] age;

  // raw_clean: no polarity or software request write yet; age: cycles since a cause
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      raw_clean  <= 1'b1;
      prio_clean <= 1'b1;
      age        <= 3'h7;
    end else begin
      if (wr_i && addr_i < A_RAW_LO) raw_clean <= 1'b0;
      if (wr_i && addr_i >= A_CFG_BASE) prio_clean <= 1'b0;
      if (wr_i || req_i != $past(req_i)) age <= 3'h0;
      else if (age != 3'h7) age <= age + 3'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  rst_zero_a:
    assert property (rstn_i && !$past(rstn_i) |-> rdata_o == '0 && !fast_interrupt_line_o
      && !std_interrupt_line_o && !int_o) else $error("outputs not clear after reset");
  rdata_idle_a:
    assert property (!$past(rd_i) |-> rdata_o == '0) else $error("read data outside read cycle");
  quiet_lines_a:
    assert property (prio_clean |-> !fast_interrupt_line_o && !std_interrupt_line_o)
      else $error("line raised with all priorities zero");
  raw_lo_a:
    assert property (raw_clean && rd_i && addr_i == A_RAW_LO && req_i == $past(req_i, 1)
      && req_i == $past(req_i, 2) && req_i == $past(req_i, 3) |=> rdata_o == $past(req_i[LO_W-1:0]))
      else $error("raw low word differs from pins");
  raw_hi_a:
    assert property (raw_clean && rd_i && addr_i == A_RAW_HI && req_i == $past(req_i, 1)
      && req_i == $past(req_i, 2) && req_i == $past(req_i, 3)
      |=> rdata_o == {8'h00, $past(req_i[NUM_REQ-1:LO_W])}) else $error("raw high word differs");
  fast_vec_a:
    assert property (rd_i && addr_i == A_VEC_F && fast_interrupt_line_o && $past(fast_interrupt_line_o)
      |=> rdata_o[VEC_HIT_POS] && rdata_o[VEC_PRIO_POS +: PRIO_W] != 4'h0 && rdata_o[5:0] < 6'h38)
      else $error("fast vector invalid while line high");
  std_vec_a:
    assert property (rd_i && addr_i == A_VEC_S && !std_interrupt_line_o && $past(!std_interrupt_line_o)
      |=> !rdata_o[VEC_HIT_POS]) else $error("std vector valid while line low");
  line_cause_a:
    assert property ($changed(fast_interrupt_line_o) || $changed(std_interrupt_line_o) |-> age <= 3'h5)
      else $error("line moved without request or write");
  cover property ($rose(fast_interrupt_line_o));
  cover property ($rose(std_interrupt_line_o));
  cover property ($rose(int_o));
endmodule

bind vrc_top vrc_chk i_vrc_chk (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .req_i(req_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fast_interrupt_line_o(fast_interrupt_line_o),
  .std_interrupt_line_o(std_interrupt_line_o), .int_o(int_o));

// File: bench/vrc_top_tb_top.sv
module vrc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vrc_pkg::*;
  logic               sys_clk_i;
  logic               rstn_i;
  logic [NUM_REQ-1:0] req_i;
  logic [ADDR_W-1:0]  addr_i;
  logic [DATA_W-1:0]  wdata_i;
  logic               wr_i;
  logic               rd_i;
  logic [DATA_W-1:0]  rdata_o;
  logic               fast_line;
  logic               std_line;
  logic               ev_int;
  logic [7:0]         fast_cnt;
  logic [7:0]         std_cnt;
  int                 errors;
  int                 total_checks;
  int                 cycles;

  vrc_top i_vrc_top (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .req_i(req_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fast_interrupt_line_o(fast_line),
    .std_interrupt_line_o(std_line), .int_o(ev_int));
  vrc_cpu_model i_vrc_cpu_model (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .fast_i(fast_line),
    .std_i(std_line), .fast_cnt_o(fast_cnt), .std_cnt_o(std_cnt));

  initial sys_clk_i = 1'b0;
  always #2 sys_clk_i = ~sys_clk_i;
  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict;
    end
  end

  task automatic chk(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge sys_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(name, rdata_o, exp);
  endtask

  // waits past the three-edge path from pin, and the two-edge path from register, to line
  task automatic line_chk(input logic f, input logic s);
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk("fast line", 32'(fast_line), 32'(f));
    chk("std line", 32'(std_line), 32'(s));
  endtask

  task automatic set_cfg(input int n, input logic [3:0] p, input logic t);
    wr(A_CFG_BASE + ADDR_W'(4 * n), 32'(p) | (32'(t) << CFG_TGT_POS));
  endtask

  function automatic logic [DATA_W-1:0] vec(input int p, input int i);
    return (32'h1 << VEC_HIT_POS) | (32'(p) << VEC_PRIO_POS) | 32'(i);
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    wr(10'h0f0, 32'hffff_ffff);
    rd_chk("unmapped", 10'h0f0, 32'h0);
    rd_chk("raw lo", A_RAW_LO, 32'h0);
    rd_chk("raw hi", A_RAW_HI, 32'h0);
    rd_chk("vector std", A_VEC_S, 32'h0);
    rd_chk("nest depth", A_NEST_LVL, 32'h0);
    line_chk(1'b0, 1'b0);
  endtask

  task automatic t_raw;
    @(posedge sys_clk_i);
    req_i[5] <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rd_chk("raw lo", A_RAW_LO, 32'h20);
    wr(A_POL_LO, 32'h20);
    rd_chk("raw lo inverted", A_RAW_LO, 32'h0);
    wr(A_POL_LO, 32'h0);
    wr(A_POL_HI, 32'h100);
    wr(A_SWSET_HI, 32'h4_0000);
    repeat (2) @(posedge sys_clk_i);
    rd_chk("raw hi", A_RAW_HI, 32'h4_0100);
    rd_chk("sw hi", A_SW_HI, 32'h4_0000);
    wr(A_SWCLR_HI, 32'h4_0000);
    wr(A_POL_HI, 32'h0);
    repeat (2) @(posedge sys_clk_i);
    rd_chk("raw hi", A_RAW_HI, 32'h0);
  endtask

  task automatic t_route;
    set_cfg(5, 4'h0, TGT_FAST);
    line_chk(1'b0, 1'b0);
    set_cfg(5, 4'h3, TGT_FAST);
    line_chk(1'b1, 1'b0);
    rd_chk("vector fast", A_VEC_F, vec(3, 5));
    wr(A_THR_F, 32'h3);
    line_chk(1'b0, 1'b0);
    wr(A_THR_F, 32'h2);
    line_chk(1'b1, 1'b0);
    set_cfg(5, 4'h3, TGT_STD);
    line_chk(1'b0, 1'b1);
    rd_chk("vector std", A_VEC_S, vec(3, 5));
  endtask

  task automatic t_arb_nest;
    wr(A_SWSET_LO, 32'h4010_0400);
    set_cfg(10, 4'h7, TGT_STD);
    set_cfg(20, 4'h7, TGT_STD);
    set_cfg(30, 4'h1, TGT_STD);
    line_chk(1'b0, 1'b1);
    rd_chk("vector tie", A_VEC_S, vec(7, 10));
    rd_chk("pending std lo", A_PNDS_LO, 32'h4010_0420);
    rd_chk("pending fast lo", A_PNDF_LO, 32'h0);
    set_cfg(20, 4'hf, TGT_STD);
    line_chk(1'b0, 1'b1);
    rd_chk("vector top", A_VEC_S, vec(15, 20));
    set_cfg(20, 4'h9, TGT_STD);
    line_chk(1'b0, 1'b1);
    wr(A_NEST_IN, 32'h2);
    line_chk(1'b0, 1'b0);
    rd_chk("nest depth", A_NEST_LVL, 32'h10);
    rd_chk("threshold std", A_THR_S, 32'h9);
    set_cfg(30, 4'hc, TGT_STD);
    line_chk(1'b0, 1'b1);
    rd_chk("vector nested", A_VEC_S, vec(12, 30));
    rd_chk("config 30", A_CFG_BASE + 10'h078, 32'h10c);
    wr(A_NEST_OUT, 32'h2);
    rd_chk("nest depth", A_NEST_LVL, 32'h0);
    rd_chk("threshold std", A_THR_S, 32'h0);
    // exit with an empty stack raises the nesting event bit
    wr(A_NEST_OUT, 32'h2);
  endtask

  task automatic t_irq;
    logic [7:0] entries;
    rd_chk("status", A_STAT, 32'h7);
    rd_chk("status cleared", A_STAT, 32'h0);
    wr(A_MASK, 32'h2);
    rd_chk("mask", A_MASK, 32'h2);
    @(posedge sys_clk_i);
    req_i[5] <= 1'b0;
    wr(A_SWCLR_LO, 32'h4010_0400);
    line_chk(1'b0, 1'b0);
    chk("event int", 32'(ev_int), 32'h0);
    entries = std_cnt;
    wr(A_SWSET_LO, 32'h4000_0000);
    line_chk(1'b0, 1'b1);
    chk("event int", 32'(ev_int), 32'h1);
    chk("std entries", 32'(std_cnt), 32'(entries + 8'h01));
    rd_chk("status", A_STAT, 32'h2);
    repeat (2) @(posedge sys_clk_i);
    chk("event int", 32'(ev_int), 32'h0);
    entries = fast_cnt;
    set_cfg(30, 4'hc, TGT_FAST);
    line_chk(1'b1, 1'b0);
    chk("fast entries", 32'(fast_cnt), 32'(entries + 8'h01));
    chk("masked int", 32'(ev_int), 32'h0);
    rd_chk("status", A_STAT, 32'h1);
  endtask

  initial begin
    rstn_i  = 1'b0;
    req_i   = '0;
    addr_i  = '0;
    wdata_i = '0;
    wr_i    = 1'b0;
    rd_i    = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    t_reset;
    t_raw;
    t_route;
    t_arb_nest;
    t_irq;
    print_verdict;
  end
endmodule
